/* design/gom_pad_route.sv */
module gom_pad_route
	import gom_pkg::*;
(
	input wire gom_cfg_t cfg,
	input wire gom_periph_t periph,
	input wire logic soft_val,
	input wire logic soft_en,
	output logic pad_val,
	output logic pad_en
);

	logic raw_val;
	logic raw_en;

	always_comb begin
		raw_val = 1'b0;
		raw_en = 1'b0;
		if (cfg.output_source_field < SRC_SOFT) begin
			raw_val = periph.value[cfg.output_source_field[7:0]]; // RULE4
			raw_en = periph.enable[cfg.output_source_field[7:0]];
		end else if (cfg.output_source_field == SRC_SOFT) begin
			raw_val = soft_val; // RULE5
			raw_en = soft_en; // RULE5
		end
		// values above 256 leave value and enable zero before the enable-source and invert bits apply
		if (cfg.enable_source_select) begin
			raw_en = soft_en; // RULE2
		end
		pad_val = raw_val ^ cfg.value_invert_select; // RULE3
		pad_en = raw_en ^ cfg.enable_invert_select; // RULE1
	end

endmodule // gom_pad_route

/* design/gom_pkg.sv */
package gom_pkg;

	// --------------------------------------------------------------
	// sizes
	// --------------------------------------------------------------
	localparam int NUM_PADS = 40;
	localparam int NUM_PERIPH = 256;
	localparam int SRC_W = 9;
	localparam int CFG_W = 12;
	localparam int HIGH_PADS = NUM_PADS - 32;

	// --------------------------------------------------------------
	// register map (byte addresses)
	// --------------------------------------------------------------
	localparam logic [31:0] GPIO_BASE = 32'h3FF4_4000;
	localparam logic [31:0] OFS_SOFT_VAL_LO = 32'h0000_0004;
	localparam logic [31:0] OFS_SOFT_VAL_HI = 32'h0000_0010;
	localparam logic [31:0] OFS_SOFT_EN_LO = 32'h0000_0020;
	localparam logic [31:0] OFS_SOFT_EN_HI = 32'h0000_002C;
	localparam logic [31:0] OFS_ROUTE_CFG = 32'h0000_0530;
	localparam logic [31:0] ADDR_PIN_CTRL = 32'h3FF4_9000;

	// --------------------------------------------------------------
	// pad_output_route_config fields
	// --------------------------------------------------------------
	localparam int SRC_LSB = 0;
	localparam int VAL_INV_BIT = 9;
	localparam int EN_SRC_BIT = 10;
	localparam int EN_INV_BIT = 11;
	localparam logic [SRC_W-1:0] SRC_SOFT = 9'h100;
	localparam logic [CFG_W-1:0] CFG_RST = 12'h100;

	// --------------------------------------------------------------
	// pin_ctrl_clock_output fields
	// --------------------------------------------------------------
	localparam int PC_SRC_LSB = 0;
	localparam int PC_SECOND_LSB = 4;
	localparam int PC_THIRD_LSB = 8;
	localparam logic [3:0] PC_AUDIO_ZERO = 4'h0;
	localparam logic [31:0] PIN_CTRL_RST = 32'h0000_0FFF;

	// --------------------------------------------------------------
	// carriers
	// --------------------------------------------------------------
	typedef struct packed {
		logic [NUM_PERIPH-1:0] value;
		logic [NUM_PERIPH-1:0] enable;
	} gom_periph_t;

	typedef struct packed {
		logic enable_invert_select;
		logic enable_source_select;
		logic value_invert_select;
		logic [SRC_W-1:0] output_source_field;
	} gom_cfg_t;

	typedef struct packed {
		logic [NUM_PADS-1:0][CFG_W-1:0] cfg;
		logic [NUM_PADS-1:0] soft_val;
		logic [NUM_PADS-1:0] soft_en;
		logic [31:0] pin_ctrl;
		logic wr_pend;
		logic [31:0] wr_addr;
		logic [31:0] rdata;
		logic [NUM_PADS-1:0] pad_val;
		logic [NUM_PADS-1:0] pad_en;
		logic clk_first;
		logic clk_second;
		logic clk_third;
	} gom_state_t;

	localparam gom_state_t STATE_RST = '{
		cfg: {NUM_PADS{CFG_RST}},
		soft_val: '0,
		soft_en: '0,
		pin_ctrl: PIN_CTRL_RST,
		wr_pend: 1'b0,
		wr_addr: 32'h0000_0000,
		rdata: 32'h0000_0000,
		pad_val: '0,
		pad_en: '0,
		clk_first: 1'b0,
		clk_second: 1'b0,
		clk_third: 1'b0
	};

endpackage

/* design/gom_route_matrix.sv */
// Behaviour
// RULE1 - enable-invert bit set inverts the pad's output enable, else passes it.
// RULE2 - enable-source bit set takes enable from software enable bit n.
// RULE3 - value-invert bit set inverts the pad's output value, else passes it.
// RULE4 - source field s below 256 connects peripheral output s to the pad.
// RULE5 - source field 256 uses software value and enable bits n.
// RULE6 - pin control [3:0] zero routes audio port zero clock to first pad.
// RULE7 - [3:0] and [7:4] zero route that clock to second pad.
// RULE8 - [3:0] and [11:8] zero route that clock to third pad.
// RULE9 - software uses only the listed nibble combinations.
// RULE10 - source field is nine bits; values above 256 are undefined.
//
// The AHB-Lite register port is this design's own decision.
module gom_route_matrix
	import gom_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire gom_periph_t periph,
	input wire logic audio_port_zero_clock,
	output logic [NUM_PADS-1:0] pad_value,
	output logic [NUM_PADS-1:0] pad_oe_n,
	output logic clock_pad_first,
	output logic clock_pad_second,
	output logic clock_pad_third
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	gom_state_t state_r;
	gom_state_t state_nxt;
	logic [NUM_PADS-1:0] route_val;
	logic [NUM_PADS-1:0] route_en;
	logic addr_phase;
	logic [31:0] wa;
	logic [31:0] ra;
	logic [31:0] rd;
	logic [3:0] pc_src;

	// --------------------------------------------------------------
	// decode and select signals
	// --------------------------------------------------------------
	logic [NUM_PADS-1:0] cfg_wr_hit;
	logic [NUM_PADS-1:0] cfg_rd_hit;
	logic val_lo_wr;
	logic val_hi_wr;
	logic en_lo_wr;
	logic en_hi_wr;
	logic pc_wr;
	logic val_lo_rd;
	logic val_hi_rd;
	logic en_lo_rd;
	logic en_hi_rd;
	logic pc_rd;
	logic [3:0] pc_second;
	logic [3:0] pc_third;
	logic src_is_audio;
	logic sel_first;
	logic sel_second;
	logic sel_third;

	// --------------------------------------------------------------
	// per-pad routing
	// --------------------------------------------------------------
	for (genvar p = 0; p < NUM_PADS; p++) begin : g_pad
		gom_pad_route u_route (
			.cfg(gom_cfg_t'(state_r.cfg[p])), // RULE10
			.periph(periph),
			.soft_val(state_r.soft_val[p]),
			.soft_en(state_r.soft_en[p]),
			.pad_val(route_val[p]),
			.pad_en(route_en[p])
		);
	end

	// --------------------------------------------------------------
	// address decode
	// --------------------------------------------------------------
	// hsize is not decoded: only whole-word accesses are expected
	assign addr_phase = hsel && hready && htrans[1];
	assign wa = state_r.wr_addr;
	assign ra = haddr;

	// writes land in the data phase, so they decode the held address
	always_comb begin
		cfg_wr_hit = '0;
		for (int i = 0; i < NUM_PADS; i++) begin
			cfg_wr_hit[i] = (wa == GPIO_BASE + OFS_ROUTE_CFG + 32'(4 * i));
		end
		val_lo_wr = (wa == GPIO_BASE + OFS_SOFT_VAL_LO);
		val_hi_wr = (wa == GPIO_BASE + OFS_SOFT_VAL_HI);
		en_lo_wr = (wa == GPIO_BASE + OFS_SOFT_EN_LO);
		en_hi_wr = (wa == GPIO_BASE + OFS_SOFT_EN_HI);
		pc_wr = (wa == ADDR_PIN_CTRL);
	end

	// reads decode the live address so the word is ready for the data phase
	always_comb begin
		cfg_rd_hit = '0;
		for (int i = 0; i < NUM_PADS; i++) begin
			cfg_rd_hit[i] = (ra == GPIO_BASE + OFS_ROUTE_CFG + 32'(4 * i));
		end
		val_lo_rd = (ra == GPIO_BASE + OFS_SOFT_VAL_LO);
		val_hi_rd = (ra == GPIO_BASE + OFS_SOFT_VAL_HI);
		en_lo_rd = (ra == GPIO_BASE + OFS_SOFT_EN_LO);
		en_hi_rd = (ra == GPIO_BASE + OFS_SOFT_EN_HI);
		pc_rd = (ra == ADDR_PIN_CTRL);
	end

	// --------------------------------------------------------------
	// clock pad select
	// --------------------------------------------------------------
	// a nonzero [3:0] leaves all three pads low; a nonzero [7:4] or [11:8] leaves only its own pad low
	always_comb begin
		pc_src = state_r.pin_ctrl[PC_SRC_LSB +: 4];
		pc_second = state_r.pin_ctrl[PC_SECOND_LSB +: 4];
		pc_third = state_r.pin_ctrl[PC_THIRD_LSB +: 4];
		src_is_audio = (pc_src == PC_AUDIO_ZERO);
		sel_first = src_is_audio; // RULE6
		sel_second = src_is_audio && (pc_second == PC_AUDIO_ZERO); // RULE7
		sel_third = src_is_audio && (pc_third == PC_AUDIO_ZERO); // RULE8
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		rd = 32'h0000_0000;

		// data phase of a write; only whole words arrive
		if (state_r.wr_pend) begin
			for (int i = 0; i < NUM_PADS; i++) begin
				if (cfg_wr_hit[i]) begin
					state_nxt.cfg[i] = hwdata[CFG_W-1:0];
				end
			end
			if (val_lo_wr) begin
				state_nxt.soft_val[31:0] = hwdata;
			end
			if (val_hi_wr) begin
				state_nxt.soft_val[NUM_PADS-1:32] = hwdata[HIGH_PADS-1:0];
			end
			if (en_lo_wr) begin
				state_nxt.soft_en[31:0] = hwdata;
			end
			if (en_hi_wr) begin
				state_nxt.soft_en[NUM_PADS-1:32] = hwdata[HIGH_PADS-1:0];
			end
			if (pc_wr) begin
				state_nxt.pin_ctrl = hwdata;
			end
		end

		// read from the updated copy so a write followed by a read sees new data
		for (int i = 0; i < NUM_PADS; i++) begin
			if (cfg_rd_hit[i]) begin
				rd = {20'h0_0000, state_nxt.cfg[i]};
			end
		end
		if (val_lo_rd) begin
			rd = state_nxt.soft_val[31:0];
		end
		if (val_hi_rd) begin
			rd = {24'h00_0000, state_nxt.soft_val[NUM_PADS-1:32]};
		end
		if (en_lo_rd) begin
			rd = state_nxt.soft_en[31:0];
		end
		if (en_hi_rd) begin
			rd = {24'h00_0000, state_nxt.soft_en[NUM_PADS-1:32]};
		end
		if (pc_rd) begin
			rd = state_nxt.pin_ctrl;
		end

		// address phase
		state_nxt.wr_pend = addr_phase && hwrite;
		if (addr_phase) begin
			state_nxt.wr_addr = haddr;
			if (!hwrite) begin
				state_nxt.rdata = rd;
			end
		end

		// pad outputs registered one cycle after the routing settles
		state_nxt.pad_val = route_val; // RULE3
		state_nxt.pad_en = route_en; // RULE1

		// selects registered so the clock gates see a steady level
		state_nxt.clk_first = sel_first; // RULE6
		state_nxt.clk_second = sel_second; // RULE7
		state_nxt.clk_third = sel_third; // RULE8
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_r <= STATE_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	// no wait states: every access completes in its first data cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = state_r.rdata;
	assign pad_value = state_r.pad_val;
	assign pad_oe_n = ~state_r.pad_en;
	// gating a clock with a flop-held select; glitch risk accepted when reprogramming
	assign clock_pad_first = audio_port_zero_clock & state_r.clk_first; // RULE6
	assign clock_pad_second = audio_port_zero_clock & state_r.clk_second; // RULE7
	assign clock_pad_third = audio_port_zero_clock & state_r.clk_third; // RULE8

endmodule // gom_route_matrix

/* tb/gom_periph_model.sv */
module gom_periph_model
	import gom_pkg::*;
(
	input logic clock,
	input logic rst,
	input logic [7:0] idx,
	output gom_periph_t periph,
	output logic audio_port_zero_clock
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// one-hot value, enable low only on the same line
	// ----
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			periph <= '0;
			audio_port_zero_clock <= 1'b0;
		end else begin
			periph.value <= NUM_PERIPH'(1) << idx;
			periph.enable <= ~(NUM_PERIPH'(1) << idx);
			audio_port_zero_clock <= ~audio_port_zero_clock;
		end
	end
endmodule // gom_periph_model

/* tb/gom_route_monitor.sv */
module gom_route_monitor
	import gom_pkg::*;
(
	input logic clock,
	input logic rst,
	input logic hsel,
	input logic [31:0] haddr,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic [31:0] hrdata,
	input gom_periph_t periph,
	input logic audio_port_zero_clock,
	input logic [NUM_PADS-1:0] pad_value,
	input logic [NUM_PADS-1:0] pad_oe_n,
	input logic clock_pad_first,
	input logic clock_pad_second,
	input logic clock_pad_third
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// checks
	// ----
	logic tk;
	logic [2:0] quiet_r;
	gom_periph_t periph_r;
	assign tk = hsel && hready && htrans[1];
	// cycles since last transfer or peripheral change
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			quiet_r <= 3'h0;
			periph_r <= '0;
		end else begin
			periph_r <= periph;
			if (tk || periph != periph_r) quiet_r <= 3'h0;
			else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence rd_zero; tk && !hwrite && haddr == 32'h0000_0000; endsequence
	sequence first_on; clock_pad_first ##2 (audio_port_zero_clock && quiet_r >= 3'h4); endsequence
	AST_READY: assert property (hreadyout) else $error("hreadyout low");
	AST_OKAY: assert property (!hresp) else $error("hresp not okay");
	AST_UNMAPPED: assert property (rd_zero |=> hrdata == 32'h0) else $error("unmapped read");
	AST_HOLD: assert property (!$past(tk && !hwrite) |-> $stable(hrdata)) else $error("hrdata moved");
	AST_PAD_QUIET: assert property (quiet_r >= 3'h4 |-> $stable(pad_value) && $stable(pad_oe_n))
		else $error("pad moved");
	AST_FIRST_HOLD: assert property (first_on |-> clock_pad_first)
		else $error("first clock pad lost");
	AST_SECOND: assert property (clock_pad_second |-> audio_port_zero_clock && clock_pad_first)
		else $error("second clock pad");
	AST_THIRD: assert property (clock_pad_third |-> audio_port_zero_clock && clock_pad_first)
		else $error("third clock pad");
endmodule // gom_route_monitor
bind gom_route_matrix gom_route_monitor i_gom_route_monitor(.clock(clock), .rst(rst), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .periph(periph), .audio_port_zero_clock(audio_port_zero_clock),
	.pad_value(pad_value), .pad_oe_n(pad_oe_n), .clock_pad_first(clock_pad_first),
	.clock_pad_second(clock_pad_second), .clock_pad_third(clock_pad_third));

/* tb/tb_gom_route_matrix.sv */
module tb_gom_route_matrix
	import gom_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0, rst = 1, hsel = 0, hwrite = 0, hreadyout, hresp, aclk, c1, c2, c3;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic [1:0] htrans = '0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] idx = '0;
	gom_periph_t periph;
	logic [NUM_PADS-1:0] pv, poe;
	int err_total = 0, checks = 0;
	logic [11:0] cv[7] = '{12'h02A, 12'h22A, 12'h82A, 12'h42A, 12'h0FF, 12'h02A, 12'hC2A};
	logic [7:0] iv[7] = '{8'h2A, 8'h2A, 8'h2A, 8'h2A, 8'hFF, 8'hFF, 8'hFF};
	logic [1:0] ev[7] = '{2'b11, 2'b01, 2'b10, 2'b10, 2'b11, 2'b00, 2'b01};
	logic [11:0] pc[5] = '{12'h000, 12'hFF0, 12'hF00, 12'h0F0, 12'hFFF};
	logic [2:0] ec[5] = '{3'h7, 3'h1, 3'h3, 3'h5, 3'h0};
	always #5 clock = ~clock;
	gom_route_matrix i_gom_route_matrix(.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .periph(periph),
		.audio_port_zero_clock(aclk), .pad_value(pv), .pad_oe_n(poe), .clock_pad_first(c1),
		.clock_pad_second(c2), .clock_pad_third(c3));
	gom_periph_model i_gom_periph_model(.clock(clock), .rst(rst), .idx(idx), .periph(periph),
		.audio_port_zero_clock(aclk));
	// ----
	// tasks
	// ----
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			$display("mismatch %s exp %h got %h", n, e, g);
			err_total++;
		end
	endtask
	task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(n, e, rd);
	endtask
	task automatic pchk(input string n, input int p, input logic [1:0] e);
		chk(n, 32'(e), 32'({pv[p], poe[p]}));
	endtask
	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic results;
		if (err_total == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		err_total++;
		results;
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rdc("cfg0", GPIO_BASE + OFS_ROUTE_CFG, 32'(CFG_RST));
		rdc("pinctrl", ADDR_PIN_CTRL, PIN_CTRL_RST);
		rdc("unmapped", 32'h0, 32'h0);
		xfer(1'b1, GPIO_BASE + OFS_SOFT_VAL_LO, 32'h0000_0001);
		xfer(1'b1, GPIO_BASE + OFS_SOFT_EN_LO, 32'h0000_0009);
		xfer(1'b1, GPIO_BASE + OFS_SOFT_VAL_HI, 32'h0000_0002);
		settle;
		pchk("pad0", 0, 2'b10);
		pchk("pad3", 3, 2'b00);
		pchk("pad33", 33, 2'b11);
		for (int i = 0; i < 7; i++) begin
			idx <= iv[i];
			xfer(1'b1, GPIO_BASE + OFS_ROUTE_CFG + 32'hC, 32'(cv[i]));
			settle;
			pchk("pad3", 3, ev[i]);
		end
		rdc("cfg3", GPIO_BASE + OFS_ROUTE_CFG + 32'hC, 32'(cv[6]));
		for (int i = 0; i < 5; i++) begin
			xfer(1'b1, ADDR_PIN_CTRL, 32'(pc[i]));
			settle;
			if (aclk !== 1'b1) begin
				@(posedge clock);
				#1;
			end
			chk("clkpads", 32'(ec[i]), 32'({c3, c2, c1}));
		end
		results;
	end
endmodule // tb_gom_route_matrix
